//--- hdl/ssg_gate.sv
`timescale 1ns/1ps
`include "ssg_regs.svh"
// --------------------------------------------------------------------
// permission table: combinational, one command class against state
// --------------------------------------------------------------------
module ssg_gate
   import ssg_pkg::*;
(
   // inputs
   input wire ssg_state_e state_i,
   input wire logic [`SSG_CLS_W-1:0] cls_i,
   input wire logic expired_i,
   // verdict
   output logic allow_o
);
   wire locked = (state_i == SSG_LOCKED_STATE);
   wire frozen = (state_i == SSG_UNLOCKED_FROZEN_STATE) |
                 (state_i == SSG_DISABLED_FROZEN);
   // one case per gated class; frozen covers both frozen states
   always_comb begin
      allow_o = 1'b1;
      case (cls_i)
         `SSG_CLS_MEDIA: allow_o = !locked;
         `SSG_CLS_FLASH_ERASE: allow_o = !locked;
         `SSG_CLS_SET_PW: allow_o = !locked && !frozen;
         `SSG_CLS_DISABLE_PW: allow_o = !locked && !frozen;
         `SSG_CLS_FREEZE: allow_o = !locked;
         `SSG_CLS_UNLOCK: allow_o = !frozen && !expired_i;
         `SSG_CLS_ERASE_UNIT: allow_o = !frozen && !expired_i;
         `SSG_CLS_ERASE_PREP: allow_o = !frozen;
         // non-media, smart and flash info always run
         default: allow_o = 1'b1;
      endcase
   end
endmodule

//--- hdl/ssg_pkg.sv
package ssg_pkg;
   // security state of the device
   typedef enum logic [2:0] {
      SSG_DISABLED_OPEN,
      SSG_DISABLED_FROZEN,
      SSG_POWERED_DOWN_SECURED_STATE,
      SSG_POWERED_DOWN_OPEN,
      SSG_LOCKED_STATE,
      SSG_UNLOCKED_OPEN_STATE,
      SSG_UNLOCKED_FROZEN_STATE
   } ssg_state_e;
endpackage

//--- hdl/ssg_regs.svh
`ifndef SSG_REGS_SVH
`define SSG_REGS_SVH
// ----------------------------------------------------------------
// command classes presented by the decoder (4 bits)
// ----------------------------------------------------------------
`define SSG_CLS_W 4
`define SSG_CLS_NONMEDIA 4'h0
`define SSG_CLS_MEDIA 4'h1
`define SSG_CLS_SMART 4'h2
`define SSG_CLS_FLASH_ERASE 4'h3
`define SSG_CLS_FLASH_INFO 4'h4
`define SSG_CLS_SET_PW 4'h5
`define SSG_CLS_UNLOCK 4'h6
`define SSG_CLS_ERASE_PREP 4'h7
`define SSG_CLS_ERASE_UNIT 4'h8
`define SSG_CLS_FREEZE 4'h9
`define SSG_CLS_DISABLE_PW 4'ha
// ----------------------------------------------------------------
// attempt counter
// ----------------------------------------------------------------
`define SSG_TRY_W 3
`define SSG_TRY_LOAD 3'h5
`define SSG_TRY_ZERO 3'h0
`define SSG_TRY_ONE 3'h1
`endif

//--- hdl/ssg_security_gate.sv
//Overview of operation
//- unlocked open plus freeze goes frozen
//- unlocked frozen reached only from unlocked open
//- power-down from unlocked goes secured down
//- hard reset from unlocked goes locked
//- frozen aborts password, unlock, erase commands
//- locked aborts media access commands
//- non-media commands run in every state
//- smart subcommands run in every state
//- locked aborts flash erase, runs translate
//- locked plus matching unlock goes unlocked
//- valid disable password goes disabled
//- prepare then erase unit goes disabled while tries remain
//- five tries loaded, zero aborts unlock
`timescale 1ns/1ps
`include "ssg_regs.svh"
module ssg_security_gate
   import ssg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // power and hardware reset events, one-cycle pulses
   input wire logic power_down_i,
   input wire logic power_up_i,
   input wire logic hard_reset_i,
   // command in, one-cycle strobe with class and password verdict
   input wire logic cmd_valid_i,
   input wire logic [`SSG_CLS_W-1:0] cmd_class_i,
   input wire logic pw_match_i,
   // verdict out, one cycle after the strobe
   output logic done_o,
   output logic exec_o,
   output logic abort_o,
   // state out
   output logic [2:0] state_o,
   output logic expired_o
);
   // ----------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------
   typedef struct packed {
      ssg_state_e st;                 // security state
      logic [`SSG_TRY_W-1:0] tries;   // unlock attempts left
      logic prep;                     // last command was erase prepare
      logic done;
      logic exec;
      logic abort;
      logic expd;                     // no attempts left, held in a flop for a clean pin
   } ssg_s;

   ssg_s cur_ff;
   ssg_s nxt_ff;
   logic allow; // gate verdict for the current command
   logic expired;

   assign expired = cur_ff.expd;

   // ----------------------------------------------------------------
   // permission lookup
   // ----------------------------------------------------------------
   ssg_gate u_gate (
      .state_i(cur_ff.st),
      .cls_i(cmd_class_i),
      .expired_i(expired),
      .allow_o(allow)
   );

   // ----------------------------------------------------------------
   // next state: power events beat hard reset, which beats commands
   // ----------------------------------------------------------------
   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.done = 1'b0;
      nxt_ff.exec = 1'b0;
      nxt_ff.abort = 1'b0;
      if (power_down_i) begin
         // secured states fall to secured power-down
         case (cur_ff.st)
            SSG_LOCKED_STATE,
            SSG_UNLOCKED_OPEN_STATE,
            SSG_UNLOCKED_FROZEN_STATE: nxt_ff.st = SSG_POWERED_DOWN_SECURED_STATE;
            SSG_DISABLED_OPEN,
            SSG_DISABLED_FROZEN: nxt_ff.st = SSG_POWERED_DOWN_OPEN;
            default: nxt_ff.st = cur_ff.st;
         endcase
         nxt_ff.prep = 1'b0;
      end else if (power_up_i) begin
         // power-up reloads the attempt counter too
         case (cur_ff.st)
            SSG_POWERED_DOWN_SECURED_STATE: nxt_ff.st = SSG_LOCKED_STATE;
            SSG_POWERED_DOWN_OPEN: nxt_ff.st = SSG_DISABLED_OPEN;
            default: nxt_ff.st = cur_ff.st;
         endcase
         nxt_ff.tries = `SSG_TRY_LOAD;
         nxt_ff.prep = 1'b0;
      end else if (hard_reset_i) begin
         // password must be given again after a hard reset
         case (cur_ff.st)
            SSG_LOCKED_STATE,
            SSG_UNLOCKED_OPEN_STATE,
            SSG_UNLOCKED_FROZEN_STATE: nxt_ff.st = SSG_LOCKED_STATE;
            SSG_DISABLED_OPEN,
            SSG_DISABLED_FROZEN: nxt_ff.st = SSG_DISABLED_OPEN;
            default: nxt_ff.st = cur_ff.st;
         endcase
         nxt_ff.tries = `SSG_TRY_LOAD;
         nxt_ff.prep = 1'b0;
      end else if (cmd_valid_i) begin
         nxt_ff.done = 1'b1;
         // any command other than erase unit breaks the prepare pairing
         nxt_ff.prep = 1'b0;
         if (!allow) begin
            nxt_ff.abort = 1'b1;
         end else begin
            nxt_ff.exec = 1'b1;
            case (cmd_class_i)
               `SSG_CLS_FREEZE: begin
                  // unlocked open freezes into unlocked frozen, disabled open into disabled frozen
                  if (cur_ff.st == SSG_UNLOCKED_OPEN_STATE) begin
                     nxt_ff.st = SSG_UNLOCKED_FROZEN_STATE;
                  end else if (cur_ff.st == SSG_DISABLED_OPEN) begin
                     nxt_ff.st = SSG_DISABLED_FROZEN;
                  end
               end
               `SSG_CLS_SET_PW: begin
                  if (cur_ff.st == SSG_DISABLED_OPEN) begin
                     nxt_ff.st = SSG_UNLOCKED_OPEN_STATE;
                  end
               end
               `SSG_CLS_UNLOCK: begin
                  if (cur_ff.st == SSG_LOCKED_STATE) begin
                     if (pw_match_i) begin
                        nxt_ff.st = SSG_UNLOCKED_OPEN_STATE;
                     end else begin
                        // failed try costs one attempt; counter stops at zero
                        nxt_ff.tries = cur_ff.tries - `SSG_TRY_ONE;
                        nxt_ff.exec = 1'b0;
                        nxt_ff.abort = 1'b1;
                     end
                  end
               end
               `SSG_CLS_DISABLE_PW: begin
                  if (cur_ff.st == SSG_UNLOCKED_OPEN_STATE && pw_match_i) begin
                     nxt_ff.st = SSG_DISABLED_OPEN;
                  end
               end
               `SSG_CLS_ERASE_PREP: nxt_ff.prep = 1'b1;
               `SSG_CLS_ERASE_UNIT: begin
                  // only directly after prepare, from locked or unlocked open
                  if (cur_ff.prep && (cur_ff.st == SSG_LOCKED_STATE ||
                      cur_ff.st == SSG_UNLOCKED_OPEN_STATE)) begin
                     nxt_ff.st = SSG_DISABLED_OPEN;
                  end else begin
                     nxt_ff.exec = 1'b0;
                     nxt_ff.abort = 1'b1;
                  end
               end
               default: nxt_ff.st = cur_ff.st;
            endcase
         end
      end
      // flag follows the count it will sit beside, so the pin needs no gate
      nxt_ff.expd = (nxt_ff.tries == `SSG_TRY_ZERO);
   end

   // ----------------------------------------------------------------
   // registers; reset means first power-on into the locked state
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cur_ff.st <= SSG_LOCKED_STATE;
         cur_ff.tries <= `SSG_TRY_LOAD;
         cur_ff.prep <= 1'b0;
         cur_ff.done <= 1'b0;
         cur_ff.exec <= 1'b0;
         cur_ff.abort <= 1'b0;
         cur_ff.expd <= 1'b0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // outputs straight from flip-flops
   assign done_o = cur_ff.done;
   assign exec_o = cur_ff.exec;
   assign abort_o = cur_ff.abort;
   assign state_o = cur_ff.st;
   assign expired_o = cur_ff.expd;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   wire quiet = !power_down_i && !power_up_i && !hard_reset_i;
   sequence s_open_freeze;
      quiet && cmd_valid_i && cmd_class_i == `SSG_CLS_FREEZE &&
      cur_ff.st == SSG_UNLOCKED_OPEN_STATE;
   endsequence
   AST_FREEZE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_open_freeze |=> cur_ff.st == SSG_UNLOCKED_FROZEN_STATE && exec_o)
      else $error("freeze did not freeze");
   AST_FROZEN_ENTRY: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      cur_ff.st == SSG_UNLOCKED_FROZEN_STATE && $past(cur_ff.st) != SSG_UNLOCKED_FROZEN_STATE
      |-> $past(cur_ff.st) == SSG_UNLOCKED_OPEN_STATE && $past(cmd_valid_i) &&
      $past(cmd_class_i) == `SSG_CLS_FREEZE)
      else $error("frozen entered without freeze");
   AST_PWR_DOWN: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      power_down_i && (cur_ff.st == SSG_UNLOCKED_OPEN_STATE ||
      cur_ff.st == SSG_UNLOCKED_FROZEN_STATE) |=> cur_ff.st == SSG_POWERED_DOWN_SECURED_STATE)
      else $error("power-down lost security");
   AST_HARD_RST: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !power_down_i && !power_up_i && hard_reset_i &&
      (cur_ff.st == SSG_UNLOCKED_OPEN_STATE || cur_ff.st == SSG_UNLOCKED_FROZEN_STATE)
      |=> cur_ff.st == SSG_LOCKED_STATE && !expired_o)
      else $error("hard reset did not lock");
   AST_FROZEN_ABORT: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      quiet && cmd_valid_i && cur_ff.st == SSG_UNLOCKED_FROZEN_STATE &&
      cmd_class_i inside {`SSG_CLS_SET_PW, `SSG_CLS_UNLOCK, `SSG_CLS_ERASE_PREP,
      `SSG_CLS_ERASE_UNIT, `SSG_CLS_DISABLE_PW} |=> abort_o && $stable(cur_ff.st))
      else $error("frozen ran a password or erase command");
   AST_LOCKED_MEDIA: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      quiet && cmd_valid_i && cur_ff.st == SSG_LOCKED_STATE &&
      cmd_class_i == `SSG_CLS_MEDIA |=> abort_o && !exec_o && $stable(cur_ff.st))
      else $error("locked ran media command");
   AST_NONMEDIA: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      quiet && cmd_valid_i && (cmd_class_i == `SSG_CLS_NONMEDIA ||
      cmd_class_i == `SSG_CLS_SMART) |=> exec_o && !abort_o)
      else $error("non-media command aborted");
   AST_FLASH: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      quiet && cmd_valid_i && cur_ff.st == SSG_LOCKED_STATE &&
      cmd_class_i == `SSG_CLS_FLASH_ERASE |=> abort_o)
      else $error("locked ran flash erase");
   AST_EXPIRED: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      quiet && cmd_valid_i && expired && cmd_class_i == `SSG_CLS_UNLOCK |=> abort_o)
      else $error("unlock ran after tries ran out");
   // an unlock with the right password opens a locked device
   sequence s_good_unlock;
      quiet && cmd_valid_i && cmd_class_i == `SSG_CLS_UNLOCK && pw_match_i && !expired &&
      cur_ff.st == SSG_LOCKED_STATE;
   endsequence
   AST_UNLOCK: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_good_unlock |=> cur_ff.st == SSG_UNLOCKED_OPEN_STATE && exec_o)
      else $error("matching unlock did not open");
   AST_DISABLE: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      quiet && cmd_valid_i && cmd_class_i == `SSG_CLS_DISABLE_PW && pw_match_i &&
      cur_ff.st == SSG_UNLOCKED_OPEN_STATE |=> cur_ff.st == SSG_DISABLED_OPEN && exec_o)
      else $error("disable password did not disable");
   // erase pair: prepare from a secured state, erase unit on the very next cycle
   sequence s_prep_taken;
      quiet && cmd_valid_i && cmd_class_i == `SSG_CLS_ERASE_PREP &&
      (cur_ff.st == SSG_LOCKED_STATE || cur_ff.st == SSG_UNLOCKED_OPEN_STATE);
   endsequence
   sequence s_unit_taken;
      quiet && cmd_valid_i && cmd_class_i == `SSG_CLS_ERASE_UNIT && !expired;
   endsequence
   AST_ERASE_PAIR: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      s_prep_taken ##1 s_unit_taken |=> cur_ff.st == SSG_DISABLED_OPEN && exec_o)
      else $error("erase pair did not disable security");
   AST_REFUSED: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      quiet && cmd_valid_i && !allow |=> abort_o && !exec_o && $stable(cur_ff.st))
      else $error("refused command ran or moved the state");
   AST_ONE_VERDICT: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      done_o == (exec_o || abort_o) && !(exec_o && abort_o))
      else $error("verdict is not exactly one of run and abort");
   AST_EVENT_DROP: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !quiet && cmd_valid_i |=> !done_o)
      else $error("command completed beside a power or reset event");
endmodule

//--- verification/ssg_host_model.sv
`timescale 1ns/1ps
`include "ssg_regs.svh"
// ----------------------------------------------------------------
// host adapter model: commands and power or reset events
// ----------------------------------------------------------------
module ssg_host_model (
   // clock
   input wire logic sys_clk_i,
   // events and command towards the gate
   output logic power_down_o,
   output logic power_up_o,
   output logic hard_reset_o,
   output logic cmd_valid_o,
   output logic [`SSG_CLS_W-1:0] cmd_class_o,
   output logic pw_match_o
);
   // quiet lines at time zero
   initial begin
      {power_down_o, power_up_o, hard_reset_o, cmd_valid_o, pw_match_o} = 5'h00;
      cmd_class_o = 4'h0;
   end
   // one command for one cycle; stale class and verdict are inverted, never held
   task automatic issue(input logic [`SSG_CLS_W-1:0] cls, input logic pw);
      @(posedge sys_clk_i);
      cmd_valid_o <= 1'b1;
      cmd_class_o <= cls;
      pw_match_o <= pw;
      @(posedge sys_clk_i);
      cmd_valid_o <= 1'b0;
      cmd_class_o <= ~cls;
      pw_match_o <= ~pw;
   endtask
   // prepare then erase unit on back-to-back cycles
   task automatic erase_pair();
      @(posedge sys_clk_i);
      cmd_valid_o <= 1'b1;
      cmd_class_o <= `SSG_CLS_ERASE_PREP;
      pw_match_o <= 1'b1;
      @(posedge sys_clk_i);
      cmd_class_o <= `SSG_CLS_ERASE_UNIT;
      @(posedge sys_clk_i);
      cmd_valid_o <= 1'b0;
      cmd_class_o <= 4'h0;
   endtask
   // one event pulse {down, up, reset}, optionally colliding with a command
   task automatic event_pulse(input logic [2:0] evt, input logic with_cmd);
      @(posedge sys_clk_i);
      {power_down_o, power_up_o, hard_reset_o} <= evt;
      cmd_valid_o <= with_cmd;
      cmd_class_o <= `SSG_CLS_NONMEDIA;
      @(posedge sys_clk_i);
      {power_down_o, power_up_o, hard_reset_o} <= 3'h0;
      cmd_valid_o <= 1'b0;
   endtask
endmodule

//--- verification/ssg_security_gate_tb.sv
`timescale 1ns/1ps
`include "ssg_regs.svh"
module ssg_security_gate_tb
   import ssg_pkg::*;
;
   // ----------------------------------------------------------------
   // signals and shorthand states
   // ----------------------------------------------------------------
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic pd, pu, hr, cv, pm, done, exec, abrt, expd;
   logic [3:0] cls;
   logic [2:0] st;
   int n_mismatch = 0;
   int cmp_count = 0;
   localparam logic [2:0] st_lk = SSG_LOCKED_STATE;
   localparam logic [2:0] st_op = SSG_UNLOCKED_OPEN_STATE;
   localparam logic [2:0] st_fz = SSG_UNLOCKED_FROZEN_STATE;
   localparam logic [2:0] st_pd = SSG_POWERED_DOWN_SECURED_STATE;
   localparam logic [2:0] st_ds = SSG_DISABLED_OPEN;
   // 40 MHz clock
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   ssg_host_model host (.sys_clk_i(sys_clk_i), .power_down_o(pd), .power_up_o(pu),
      .hard_reset_o(hr), .cmd_valid_o(cv), .cmd_class_o(cls), .pw_match_o(pm));
   ssg_security_gate uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .power_down_i(pd),
      .power_up_i(pu), .hard_reset_i(hr), .cmd_valid_i(cv), .cmd_class_i(cls),
      .pw_match_i(pm), .done_o(done), .exec_o(exec), .abort_o(abrt), .state_o(st),
      .expired_o(expd));
   // ----------------------------------------------------------------
   // shared checks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // answer lands on the same edge that takes the command; look once it has settled
   task automatic resp(input logic ex, input logic [2:0] s);
      #1;
      chk("done", 4'h1, {3'h0, done});
      chk("exec", {3'h0, ex}, {3'h0, exec});
      chk("abort", {3'h0, ~ex}, {3'h0, abrt});
      chk("state", {1'b0, s}, {1'b0, st});
   endtask
   task automatic cmd(input logic [3:0] c, input logic p, input logic ex, input logic [2:0] s);
      host.issue(c, p);
      resp(ex, s);
   endtask
   // an event colliding with a command must drop that command
   task automatic evt(input logic [2:0] e, input logic wc, input logic [2:0] s);
      host.event_pulse(e, wc);
      #1;
      chk("state", {1'b0, s}, {1'b0, st});
      chk("dropped", 4'h0, {3'h0, done});
   endtask
   task automatic do_reset();
      // a mid-run reset is raised on an edge, like every other input
      if (resetn_i) @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      #1;
      chk("reset state", {1'b0, st_lk}, {1'b0, st});
      chk("expired", 4'h0, {3'h0, expd});
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_locked();
      logic [31:0] lc = 32'ha954_3210;
      for (int i = 0; i < 8; i++) begin
         cmd(lc[4*i +: 4], 1'b1, i < 5 && !i[0], st_lk);
      end
   endtask
   // five failed unlocks expire the counter; a hardware reset reloads it
   task automatic s_tries();
      for (int i = 0; i < 5; i++) begin
         cmd(`SSG_CLS_UNLOCK, 1'b0, 1'b0, st_lk);
         chk("expired", {3'h0, i == 4}, {3'h0, expd});
      end
      cmd(`SSG_CLS_UNLOCK, 1'b1, 1'b0, st_lk);
      host.erase_pair();
      resp(1'b0, st_lk);
      evt(3'h1, 1'b1, st_lk);
      chk("expired", 4'h0, {3'h0, expd});
      cmd(`SSG_CLS_UNLOCK, 1'b1, 1'b1, st_op);
   endtask
   task automatic s_frozen();
      logic [43:0] fc = 44'ha87_6594_3210;
      for (int i = 0; i < 5; i++) cmd(i[3:0], 1'b1, 1'b1, st_op);
      cmd(`SSG_CLS_FREEZE, 1'b0, 1'b1, st_fz);
      for (int i = 0; i < 11; i++) begin
         cmd(fc[4*i +: 4], 1'b1, i < 6, st_fz);
      end
      evt(3'h4, 1'b1, st_pd);
      evt(3'h2, 1'b0, st_lk);
      cmd(`SSG_CLS_UNLOCK, 1'b1, 1'b1, st_op);
      evt(3'h1, 1'b0, st_lk);
      cmd(`SSG_CLS_UNLOCK, 1'b1, 1'b1, st_op);
      cmd(`SSG_CLS_FREEZE, 1'b0, 1'b1, st_fz);
      evt(3'h1, 1'b1, st_lk);
      cmd(`SSG_CLS_UNLOCK, 1'b1, 1'b1, st_op);
      evt(3'h4, 1'b0, st_pd);
   endtask
   task automatic s_erase();
      do_reset();
      cmd(`SSG_CLS_ERASE_UNIT, 1'b1, 1'b0, st_lk);
      cmd(`SSG_CLS_ERASE_PREP, 1'b1, 1'b1, st_lk);
      cmd(`SSG_CLS_NONMEDIA, 1'b1, 1'b1, st_lk);
      cmd(`SSG_CLS_ERASE_UNIT, 1'b1, 1'b0, st_lk);
      host.erase_pair();
      resp(1'b1, st_ds);
      do_reset();
      cmd(`SSG_CLS_UNLOCK, 1'b1, 1'b1, st_op);
      host.erase_pair();
      resp(1'b1, st_ds);
      do_reset();
      cmd(`SSG_CLS_UNLOCK, 1'b1, 1'b1, st_op);
      cmd(`SSG_CLS_DISABLE_PW, 1'b0, 1'b1, st_op);
      cmd(`SSG_CLS_DISABLE_PW, 1'b1, 1'b1, st_ds);
      // disabled side: freeze, refused password, power cycle, fresh password
      cmd(`SSG_CLS_FREEZE, 1'b0, 1'b1, SSG_DISABLED_FROZEN);
      cmd(`SSG_CLS_SET_PW, 1'b1, 1'b0, SSG_DISABLED_FROZEN);
      evt(3'h4, 1'b1, SSG_POWERED_DOWN_OPEN);
      evt(3'h2, 1'b0, st_ds);
      cmd(`SSG_CLS_SET_PW, 1'b1, 1'b1, st_op);
   endtask
   // watchdog against a hung run
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      do_reset();
      s_locked();
      s_tries();
      s_frozen();
      s_erase();
      report_and_stop();
   end
endmodule
